/* File: core/cie_dev_end.sv */
// Device end: control input evaluation and per-output restart interlock
//
// How it works
// - complementary pair 10 means 0, 01 means 1
// - controller keeps every pair inverted unless user_one_of_n selects one-hot drive
// - equal pair forces outputs OFF, flags error
// - one-of-n needs exactly one high channel
// - position of the high channel selects case
// - interruption holds output OFF at least 80 ms
// - long network expectation needs interlock enabled
// - each output has switchable restart interlock
// - interlock reset arrives as network signal
// - interlocked output stays OFF after field clears
// - interlocked output turns ON only by reset
// - reset ignored while field still occupied
// - reset needs all functions operational, clears start-up
// - controller starts motion only after separate start
`default_nettype none
`include "cie_consts.svh"
module cie_dev_end
  import cie_pkg::*;
#(
  parameter int NUM_INPUTS  = `CIE_NUM_INPUTS,
  parameter int NUM_OUTPUTS = `CIE_NUM_OUTPUTS,
  parameter int MIN_OFF_CYC = `CIE_MIN_OFF_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  cie_link_if.dev                     link,
  input  wire logic                   eval_one_of_n,
  input  wire logic [NUM_OUTPUTS-1:0] lock_enable,
  input  wire logic [NUM_OUTPUTS-1:0] field_clear,
  input  wire logic                   funcs_ok,
  output var  logic [NUM_INPUTS-1:0]  input_value,
  output var  logic [`CIE_CASE_W-1:0] case_index,
  output var  logic                   case_valid,
  output var  logic                   startup_lock
);
  localparam int CNT_W = $clog2(MIN_OFF_CYC + 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(MIN_OFF_CYC - 1);

  typedef struct packed {
    logic [NUM_INPUTS-1:0]  val;
    logic [`CIE_CASE_W-1:0] idx;
    logic                   err;
    logic                   startup;
    logic [NUM_OUTPUTS-1:0] out;
  } cie_dev_core_type;

  cie_dev_core_type              st_q;
  cie_dev_core_type              st_d;
  cie_lock_type                  lk_q [NUM_OUTPUTS];
  cie_lock_type                  lk_d [NUM_OUTPUTS];
  logic [CNT_W-1:0]              cnt_q [NUM_OUTPUTS];
  logic [CNT_W-1:0]              cnt_d [NUM_OUTPUTS];
  logic                          bad_in;
  logic [`CIE_CASE_W-1:0]        hot_idx;
  int unsigned                   hot_cnt;

  // ---------------------------------------------------------------
  // Control input decode
  // ---------------------------------------------------------------
  always_comb begin
    bad_in = 1'b0;
    hot_cnt = 0;
    hot_idx = '0;
    if (eval_one_of_n) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (link.chan_one[i]) begin
          hot_cnt = hot_cnt + 1;
          hot_idx = `CIE_CASE_W'(2 * i);
        end
        if (link.chan_two[i]) begin
          hot_cnt = hot_cnt + 1;
          hot_idx = `CIE_CASE_W'(2 * i + 1);
        end
      end
      bad_in = (hot_cnt != 1);
    end else begin
      bad_in = |(~(link.chan_one ^ link.chan_two));
    end
  end

  // ---------------------------------------------------------------
  // Next state: decode results and interlocks
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.err = bad_in;
    if (!bad_in) begin
      if (eval_one_of_n) begin
        st_d.idx = hot_idx;
      end else begin
        st_d.val = link.chan_two;
      end
    end
    for (int k = 0; k < NUM_OUTPUTS; k++) begin
      lk_d[k] = lk_q[k];
      cnt_d[k] = cnt_q[k];
      case (lk_q[k])
        CIE_LK_ON: begin
          if (!field_clear[k] || bad_in) begin
            lk_d[k] = CIE_LK_HOLD;
            cnt_d[k] = '0;
          end
        end
        CIE_LK_HOLD: begin
          if (cnt_q[k] != HOLD_LAST) begin
            cnt_d[k] = cnt_q[k] + CNT_W'(1);
          end else if (!field_clear[k] || bad_in) begin
            cnt_d[k] = cnt_q[k];
          end else if (lock_enable[k] || st_q.startup) begin
            lk_d[k] = CIE_LK_WAIT_RESET;
          end else begin
            lk_d[k] = CIE_LK_ON;
          end
        end
        CIE_LK_WAIT_RESET: begin
          if (!field_clear[k] || bad_in) begin
            lk_d[k] = CIE_LK_HOLD;
            cnt_d[k] = '0;
          end else if (link.net_reset[k] && funcs_ok) begin
            lk_d[k] = CIE_LK_ON;
          end
        end
        default: begin
          lk_d[k] = CIE_LK_HOLD;
          cnt_d[k] = '0;
        end
      endcase
      st_d.out[k] = (lk_d[k] == CIE_LK_ON) && !bad_in;
    end
    if (funcs_ok && !bad_in && (|link.net_reset) && (&field_clear)) begin
      st_d.startup = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{val: '0, idx: '0, err: 1'b0, startup: 1'b1, out: '0};
      for (int k = 0; k < NUM_OUTPUTS; k++) begin
        lk_q[k] <= CIE_LK_HOLD;
        cnt_q[k] <= '0;
      end
    end else begin
      st_q <= st_d;
      for (int k = 0; k < NUM_OUTPUTS; k++) begin
        lk_q[k] <= lk_d[k];
        cnt_q[k] <= cnt_d[k];
      end
    end
  end

  assign link.safe_out = st_q.out;
  assign link.input_error = st_q.err;
  assign input_value = st_q.val;
  assign case_index = st_q.idx;
  assign case_valid = !st_q.err;
  assign startup_lock = st_q.startup;
endmodule
`default_nettype wire

/* File: pkg/cie_consts.svh */
// Constants for the case input evaluation and restart interlock block
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH
`define CIE_CLK_PERIOD_NS 8
`define CIE_MIN_OFF_MS 80
`define CIE_MIN_OFF_CYC ((`CIE_MIN_OFF_MS * 1000000 + `CIE_CLK_PERIOD_NS - 1) / `CIE_CLK_PERIOD_NS)
`define CIE_NUM_INPUTS 2
`define CIE_NUM_OUTPUTS 2
`define CIE_CASE_W 3
`endif

/* File: pkg/cie_pkg.sv */
// Types for the case input evaluation and restart interlock block
`default_nettype none
package cie_pkg;
  typedef enum logic [0:0] {
    CIE_EVAL_COMPL = 1'b0,
    CIE_EVAL_ONE_OF_N = 1'b1
  } cie_eval_type;

  typedef enum logic [1:0] {
    CIE_LK_ON = 2'b00,
    CIE_LK_HOLD = 2'b01,
    CIE_LK_WAIT_RESET = 2'b10
  } cie_lock_type;
endpackage
`default_nettype wire

/* File: pkg/cie_link_if.sv */
// Link between the safety controller and the case evaluation device
`default_nettype none
interface cie_link_if #(
  parameter int NUM_INPUTS  = 2,
  parameter int NUM_OUTPUTS = 2
);
  logic [NUM_INPUTS-1:0]  chan_one;
  logic [NUM_INPUTS-1:0]  chan_two;
  logic [NUM_OUTPUTS-1:0] net_reset;
  logic [NUM_OUTPUTS-1:0] safe_out;
  logic                   input_error;

  modport dev (
    input  chan_one,
    input  chan_two,
    input  net_reset,
    output safe_out,
    output input_error
  );
  modport ctl (
    output chan_one,
    output chan_two,
    output net_reset,
    input  safe_out,
    input  input_error
  );
endinterface
`default_nettype wire

/* File: core/cie_ctl_end.sv */
// Controller end: drives control input channels and interlock resets
`default_nettype none
`include "cie_consts.svh"
module cie_ctl_end
  import cie_pkg::*;
#(
  parameter int NUM_INPUTS  = `CIE_NUM_INPUTS,
  parameter int NUM_OUTPUTS = `CIE_NUM_OUTPUTS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  cie_link_if.ctl                     link,
  input  wire logic [NUM_INPUTS-1:0]  user_in_val,
  input  wire logic [1:0]             user_case_sel,
  input  wire logic                   user_one_of_n,
  input  wire logic [NUM_OUTPUTS-1:0] user_reset,
  input  wire logic [NUM_OUTPUTS-1:0] user_start,
  output var  logic [NUM_OUTPUTS-1:0] user_safe_seen,
  output var  logic                   user_error_seen,
  output var  logic [NUM_OUTPUTS-1:0] user_motion_ok
);
  typedef struct packed {
    logic [NUM_INPUTS-1:0]  one;
    logic [NUM_INPUTS-1:0]  two;
    logic [NUM_OUTPUTS-1:0] rst;
    logic [NUM_OUTPUTS-1:0] seen;
    logic                   err;
    logic [NUM_OUTPUTS-1:0] armed;
    logic [NUM_OUTPUTS-1:0] motion;
  } cie_ctl_state_type;

  cie_ctl_state_type st_q;
  cie_ctl_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (user_one_of_n) begin
      // One-hot over all channels, chan_one of input 0 first
      st_d.one = '0;
      st_d.two = '0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (user_case_sel == 2'(2 * i)) begin
          st_d.one[i] = 1'b1;
        end
        if (user_case_sel == 2'(2 * i + 1)) begin
          st_d.two[i] = 1'b1;
        end
      end
    end else begin
      st_d.one = ~user_in_val;
      st_d.two = user_in_val;
    end
    st_d.rst = user_reset;
    st_d.seen = link.safe_out;
    st_d.err = link.input_error;
    // A reset arms, a falling output disarms; motion needs an armed start with the output ON
    for (int j = 0; j < NUM_OUTPUTS; j++) begin
      if (user_reset[j]) begin
        st_d.armed[j] = 1'b1;
        st_d.motion[j] = 1'b0;
      end else if (!link.safe_out[j]) begin
        st_d.motion[j] = 1'b0;
        if (st_q.seen[j]) begin
          st_d.armed[j] = 1'b0;
        end
      end else if (user_start[j] && st_q.armed[j]) begin
        st_d.motion[j] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{one: '1, two: '0, rst: '0, seen: '0, err: 1'b0,
                armed: '0, motion: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign link.chan_one = st_q.one;
  assign link.chan_two = st_q.two;
  assign link.net_reset = st_q.rst;
  assign user_safe_seen = st_q.seen;
  assign user_error_seen = st_q.err;
  assign user_motion_ok = st_q.motion;
endmodule
`default_nettype wire

/* File: verif/cie_link_assertions.sv */
// Checker for the link between the controller end and the device end
`default_nettype none
module cie_link_assertions #(
  parameter int MIN_OFF_CYC = 20
) (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [1:0] chan_one,
  input wire logic [1:0] chan_two,
  input wire logic [1:0] net_reset,
  input wire logic [1:0] safe_out,
  input wire logic       input_error,
  input wire logic       eval_one_of_n,
  input wire logic [1:0] field_clear,
  input wire logic [1:0] lock_enable
);
  // ----------------------------------------
  // Off time of output 0, saturating
  // ----------------------------------------
  logic [31:0] off_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) off_q <= 32'h0;
    else if (safe_out[0]) off_q <= 32'h0;
    else if (off_q < 32'(MIN_OFF_CYC)) off_q <= off_q + 32'h1;
  end
  sequence s_rise;
    !safe_out[0] ##1 safe_out[0];
  endsequence
  sequence s_lock_rise;
    !safe_out[0] ##1 (safe_out[0] && lock_enable[0]);
  endsequence
  pair_bad_a: assert property (!eval_one_of_n && |(chan_one ~^ chan_two) |=> input_error)
    else $error("equal pair not flagged");
  pair_good_a: assert property (!eval_one_of_n && &(chan_one ^ chan_two) |=> !input_error)
    else $error("inverted pair flagged");
  count_bad_a: assert property (eval_one_of_n && !$onehot({chan_two, chan_one}) |=> input_error)
    else $error("bad channel count not flagged");
  count_good_a: assert property (eval_one_of_n && $onehot({chan_two, chan_one}) |=> !input_error)
    else $error("single channel flagged");
  error_off_a: assert property (input_error |=> safe_out == 2'h0)
    else $error("output on during error");
  field_off_a: assert property (!field_clear[0] |=> !safe_out[0])
    else $error("output on with field occupied");
  min_off_a: assert property (s_rise |-> off_q >= 32'(MIN_OFF_CYC))
    else $error("off time too short");
  lock_reset_a: assert property (s_lock_rise |-> $past(net_reset[0]))
    else $error("locked output on without reset");
  reset_ignored_a: assert property (net_reset[0] && !field_clear[0] |=> !safe_out[0])
    else $error("reset taken with field occupied");
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Testbench joining the controller end and the device end
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MOC = 20;
  logic       ref_clk, rst_b, one_of_n, eval_one_of_n, funcs_ok, error_seen, case_valid;
  logic       startup_lock;
  logic [1:0] in_val, case_sel, user_reset, user_start, lock_enable, field_clear;
  logic [1:0] safe_seen, motion_ok, input_value;
  logic [2:0] case_index;
  int         errors, checks_done;
  cie_link_if link ();
  cie_ctl_end cie_ctl_end_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link),
    .user_in_val(in_val), .user_case_sel(case_sel), .user_one_of_n(one_of_n),
    .user_reset(user_reset), .user_start(user_start), .user_safe_seen(safe_seen),
    .user_error_seen(error_seen), .user_motion_ok(motion_ok));
  cie_dev_end #(.MIN_OFF_CYC(MOC)) cie_dev_end_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(link), .eval_one_of_n(eval_one_of_n), .lock_enable(lock_enable),
    .field_clear(field_clear), .funcs_ok(funcs_ok), .input_value(input_value),
    .case_index(case_index), .case_valid(case_valid), .startup_lock(startup_lock));
  cie_link_assertions #(.MIN_OFF_CYC(MOC)) cie_link_assertions_i (.ref_clk(ref_clk),
    .rst_b(rst_b), .chan_one(link.chan_one), .chan_two(link.chan_two),
    .net_reset(link.net_reset), .safe_out(link.safe_out), .input_error(link.input_error),
    .eval_one_of_n(eval_one_of_n), .field_clear(field_clear), .lock_enable(lock_enable));
  // ----------------------------------------
  // Clock and tasks
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic send_reset(input logic [1:0] m);
    user_reset = m;
    cyc(1);
    user_reset = 2'h0;
    cyc(3);
  endtask
  task automatic wait_safe(input logic [1:0] m);
    int n;
    n = 0;
    while (link.safe_out !== m && n < 100) begin
      cyc(1);
      n++;
    end
    chk("safe_out", 4'(link.safe_out), 4'(m));
    if (n >= 100) report_and_stop();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    {one_of_n, eval_one_of_n, in_val, case_sel, user_reset, user_start} = 10'h0;
    {funcs_ok, lock_enable, field_clear} = 5'h07;
    errors = 0;
    checks_done = 0;
    cyc(10);
    rst_b = 1'b1;
    cyc(30);
    chk("startup_off", 4'(link.safe_out), 4'h0);
    funcs_ok = 1'b0;
    send_reset(2'h1);
    chk("reset_no_funcs", 4'(link.safe_out), 4'h0);
    funcs_ok = 1'b1;
    send_reset(2'h3);
    wait_safe(2'h3);
    chk("startup_lock", 4'(startup_lock), 4'h0);
    chk("motion_early", 4'(motion_ok), 4'h0);
    user_start = 2'h1;
    cyc(1);
    user_start = 2'h0;
    cyc(2);
    chk("motion_ok", 4'(motion_ok), 4'h1);
    chk("safe_seen", 4'(safe_seen), 4'h3);
    for (int v = 0; v < 4; v++) begin
      in_val = 2'(v);
      cyc(3);
      chk("input_value", 4'(input_value), 4'(v));
      chk("chan_two", 4'(link.chan_two), 4'(v));
      chk("chan_one", 4'(link.chan_one), 4'(~v & 3));
    end
    one_of_n = 1'b1;
    eval_one_of_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      case_sel = 2'(c);
      cyc(3);
      chk("case_index", 4'(case_index), 4'(c));
      chk("one_hot", {link.chan_two[1], link.chan_one[1], link.chan_two[0],
        link.chan_one[0]}, 4'(4'h1 << c));
      chk("case_valid", 4'(case_valid), 4'h1);
    end
    // Case 3 pattern read as pairs leaves pair A at 00
    eval_one_of_n = 1'b0;
    cyc(3);
    chk("pair_error", 4'(link.input_error), 4'h1);
    chk("error_seen", 4'(error_seen), 4'h1);
    chk("error_off", 4'(link.safe_out), 4'h0);
    eval_one_of_n = 1'b1;
    one_of_n = 1'b0;
    cyc(3);
    chk("count_error", 4'(case_valid), 4'h0);
    chk("index_held", 4'(case_index), 4'h3);
    eval_one_of_n = 1'b0;
    cyc(3);
    chk("error_clear", 4'(link.input_error), 4'h0);
    wait_safe(2'h2);
    send_reset(2'h1);
    wait_safe(2'h3);
    field_clear = 2'h0;
    cyc(1);
    field_clear = 2'h3;
    cyc(10);
    chk("short_hold", 4'(link.safe_out), 4'h0);
    wait_safe(2'h2);
    cyc(5);
    chk("stays_off", 4'(link.safe_out), 4'h2);
    field_clear = 2'h2;
    send_reset(2'h1);
    chk("occupied", 4'(link.safe_out), 4'h2);
    field_clear = 2'h3;
    cyc(2);
    send_reset(2'h1);
    chk("reset_in_hold", 4'(link.safe_out), 4'h2);
    cyc(MOC);
    send_reset(2'h1);
    wait_safe(2'h3);
    report_and_stop();
  end
endmodule
`default_nettype wire
